/* File: pkg/pfm_pkg.sv */
// Constants for the port pin function multiplexer.
// Assumes a 32-bit AHB-Lite register port and a 10 MHz system clock.
package pfm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PFM_OFS_CPU_CTRL = 8'h00;
  localparam logic [7:0] PFM_OFS_IFC_CFG = 8'h04;
  localparam logic [7:0] PFM_OFS_PA_SEL = 8'h08;
  localparam logic [7:0] PFM_OFS_PC_SEL = 8'h0c;
  localparam logic [7:0] PFM_OFS_PE_SEL = 8'h10;
  localparam logic [7:0] PFM_OFS_FIFO_POL = 8'h14;
  localparam logic [7:0] PFM_OFS_WAKEUP = 8'h18;
  localparam logic [7:0] PFM_OFS_EP_CFG = 8'h1c;
  localparam logic [7:0] PFM_OFS_TMR_IRQ = 8'h20;
  localparam logic [7:0] PFM_OFS_STATUS = 8'h24;
  localparam logic [7:0] PFM_OFS_PORT_DATA = 8'h40;
  localparam logic [7:0] PFM_OFS_PORT_DIR = 8'h60;
  localparam logic [7:0] PFM_OFS_PORT_PIN = 8'h80;
  localparam logic [7:0] PFM_OFS_GROUP_MASK = 8'he0;
  localparam logic [2:0] PFM_NUM_PORTS = 3'd5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PFM_RST_CPU_CTRL = 8'h00;
  localparam logic [7:0] PFM_RST_CFG = 8'h00;
  localparam logic [7:0] PFM_RST_PORT = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PFM_BIT_CLK_TRISTATE = 1;
  localparam int PFM_BIT_CLK_SPEED_LO = 3;
  localparam int PFM_BIT_WAKE_EN = 1;
  localparam int PFM_BIT_WAKE_POL = 4;
  localparam int PFM_BIT_SLV_OE_POL = 4;
  localparam int PFM_BIT_COMMIT_POL = 5;
  localparam int PFM_BIT_WORDWIDE = 0;
  localparam int PFM_BIT_T0_MODE3 = 2;
  localparam int PFM_BIT_T1_MODE3 = 3;

  // ----------------------------------------------------------------
  // Interface modes and code space
  // ----------------------------------------------------------------
  localparam logic [1:0] PFM_MODE_PORT = 2'b00;
  localparam logic [1:0] PFM_MODE_WAVE = 2'b10;
  localparam logic [1:0] PFM_MODE_SLAVE = 2'b11;
  localparam logic [15:0] PFM_CODE_INT_LAST = 16'h3fff;

  // ----------------------------------------------------------------
  // Clock output divider, half periods minus one in clk cycles, and pin synchroniser width
  // ----------------------------------------------------------------
  localparam logic [1:0] PFM_HALF_SLOW = 2'd3;
  localparam logic [1:0] PFM_HALF_MID = 2'd1;
  localparam logic [1:0] PFM_HALF_FAST = 2'd0;
  localparam int PFM_SYNC_WIDTH = 42;

endpackage : pfm_pkg

/* File: rtl/pfm_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
module pfm_sync #(
  parameter int W = 42
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      q <= '0;
    end else begin
      stage1_reg <= d;
      q <= stage1_reg;
    end
  end
endmodule : pfm_sync

/* File: rtl/pfm_clock_out.sv */
// Processor clock output divider with three speeds.
// Assumes speed select comes from a register on clk.
`timescale 1ns/10ps
module pfm_clock_out
  import pfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] speed,
  output logic clk_out,
  output logic rise_tick
);
  logic [1:0] cnt_reg;
  logic [1:0] half;

  always_comb begin
    case (speed)
      2'd0: half = PFM_HALF_SLOW;
      2'd1: half = PFM_HALF_MID;
      default: half = PFM_HALF_FAST;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'd0;
      clk_out <= 1'b0;
      rise_tick <= 1'b0;
    end else if (cnt_reg >= half) begin
      cnt_reg <= 2'd0;
      clk_out <= !clk_out;
      rise_tick <= !clk_out;
    end else begin
      cnt_reg <= cnt_reg + 2'd1;
      rise_tick <= 1'b0;
    end
  end
endmodule : pfm_clock_out

/* File: rtl/pfm_port_mux.sv */
// Pin function multiplexer for ports A to E and system pins.
// Assumes an AHB-Lite master on clk and pins asynchronous to clk.
`timescale 1ns/10ps
module pfm_port_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic chip_reset_n,
  input wire logic external_code_select,
  input wire logic [15:0] fetch_address,
  output logic code_fetch_external,
  output logic chip_reset_active,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe,
  output logic processor_clock_output,
  output logic processor_clock_output_oe,
  input wire logic [15:0] fifo_data_out,
  input wire logic fifo_data_drive,
  input wire logic fifo_status_flag_d,
  input wire logic [8:0] waveform_address_out,
  input wire logic uart0_rx_out,
  input wire logic uart1_rx_out,
  input wire logic timer0_overflow,
  input wire logic timer0_low_overflow,
  input wire logic timer1_overflow,
  input wire logic timer1_low_overflow,
  input wire logic timer2_overflow,
  input wire logic suspended,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic [15:0] fifo_data_in,
  output logic slave_output_enable,
  output logic [1:0] fifo_select,
  output logic packet_commit,
  output logic slave_chip_select,
  output logic int6_in,
  output logic timer2_reload_in,
  output logic oscillator_restart,
  output logic wakeup_irq,
  output logic suspend_inhibit
);
  import pfm_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock output
  // ----------------------------------------------------------------
  logic [41:0] sync_q;
  logic [7:0] pa, pb, pc, pd, pe, pa_prev_reg;
  logic reset_n_s, ext_sel_s, soft_rst, clk_fast_w, rise_tick;
  logic [7:0] cpu_ctrl_reg, ifc_cfg_reg, pa_sel_reg, pc_sel_reg;
  logic [7:0] pe_sel_reg, fifo_pol_reg, wakeup_reg, ep_cfg_reg, tmr_irq_reg;
  logic [7:0] port_data_reg [0:4];
  logic [7:0] port_dir_reg [0:4];

  pfm_sync #(.W(PFM_SYNC_WIDTH)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({chip_reset_n, external_code_select, port_e_in, port_d_in,
        port_c_in, port_b_in, port_a_in}),
    .q(sync_q)
  );
  assign {reset_n_s, ext_sel_s, pe, pd, pc, pb, pa} = sync_q;
  assign soft_rst = !reset_n_s;

  pfm_clock_out u_clk_out (
    .clk(clk),
    .rst(rst),
    .speed(cpu_ctrl_reg[PFM_BIT_CLK_SPEED_LO+1:PFM_BIT_CLK_SPEED_LO]),
    .clk_out(clk_fast_w),
    .rise_tick(rise_tick)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes zero wait, reads one wait state
  // ----------------------------------------------------------------
  logic addr_phase, wr_pend_reg, rd_pend_reg, addr_hi_reg;
  logic [7:0] addr_reg, rd_byte;
  logic [2:0] port_idx;
  logic port_ok;

  assign addr_phase = hsel && htrans[1] && hready;
  assign port_idx = addr_reg[4:2];
  assign port_ok = !addr_hi_reg && (port_idx < PFM_NUM_PORTS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      addr_hi_reg <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      hreadyout <= !(addr_phase && !hwrite);
      hresp <= 1'b0;
      if (addr_phase) begin
        addr_reg <= haddr[7:0];
        addr_hi_reg <= |haddr[31:8];
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (!addr_hi_reg) begin
      case (addr_reg)
        PFM_OFS_CPU_CTRL: rd_byte = cpu_ctrl_reg;
        PFM_OFS_IFC_CFG: rd_byte = ifc_cfg_reg;
        PFM_OFS_PA_SEL: rd_byte = pa_sel_reg;
        PFM_OFS_PC_SEL: rd_byte = pc_sel_reg;
        PFM_OFS_PE_SEL: rd_byte = pe_sel_reg;
        PFM_OFS_FIFO_POL: rd_byte = fifo_pol_reg;
        PFM_OFS_WAKEUP: rd_byte = wakeup_reg;
        PFM_OFS_EP_CFG: rd_byte = ep_cfg_reg;
        PFM_OFS_TMR_IRQ: rd_byte = tmr_irq_reg;
        PFM_OFS_STATUS: rd_byte = {4'h0, suspend_inhibit, ext_irq_one,
                                   ext_irq_zero, code_fetch_external};
        default: rd_byte = 8'h00;
      endcase
      if (port_ok && (addr_reg[1:0] == 2'b00)) begin
        case (addr_reg & PFM_OFS_GROUP_MASK)
          PFM_OFS_PORT_DATA: rd_byte = port_data_reg[port_idx];
          PFM_OFS_PORT_DIR: rd_byte = port_dir_reg[port_idx];
          PFM_OFS_PORT_PIN: rd_byte = sync_q[port_idx*8 +: 8];
          default: rd_byte = rd_byte;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ctrl_reg <= PFM_RST_CPU_CTRL;
      ifc_cfg_reg <= PFM_RST_CFG;
      pa_sel_reg <= PFM_RST_CFG;
      pc_sel_reg <= PFM_RST_CFG;
      pe_sel_reg <= PFM_RST_CFG;
      fifo_pol_reg <= PFM_RST_CFG;
      wakeup_reg <= PFM_RST_CFG;
      ep_cfg_reg <= PFM_RST_CFG;
      tmr_irq_reg <= PFM_RST_CFG;
      for (int i = 0; i < 5; i++) begin
        port_data_reg[i] <= PFM_RST_PORT;
        port_dir_reg[i] <= PFM_RST_PORT;
      end
    end else if (soft_rst) begin
      cpu_ctrl_reg <= PFM_RST_CPU_CTRL;
      ifc_cfg_reg <= PFM_RST_CFG;
      pa_sel_reg <= PFM_RST_CFG;
      pc_sel_reg <= PFM_RST_CFG;
      pe_sel_reg <= PFM_RST_CFG;
      fifo_pol_reg <= PFM_RST_CFG;
      wakeup_reg <= PFM_RST_CFG;
      ep_cfg_reg <= PFM_RST_CFG;
      tmr_irq_reg <= PFM_RST_CFG;
      for (int i = 0; i < 5; i++) begin
        port_data_reg[i] <= PFM_RST_PORT;
        port_dir_reg[i] <= PFM_RST_PORT;
      end
    end else if (wr_pend_reg && !addr_hi_reg) begin
      case (addr_reg)
        PFM_OFS_CPU_CTRL: cpu_ctrl_reg <= {2'b00, hwdata[5:0]};
        PFM_OFS_IFC_CFG: ifc_cfg_reg <= hwdata[7:0];
        PFM_OFS_PA_SEL: pa_sel_reg <= hwdata[7:0];
        PFM_OFS_PC_SEL: pc_sel_reg <= hwdata[7:0];
        PFM_OFS_PE_SEL: pe_sel_reg <= hwdata[7:0];
        PFM_OFS_FIFO_POL: fifo_pol_reg <= hwdata[7:0];
        PFM_OFS_WAKEUP: wakeup_reg <= hwdata[7:0];
        PFM_OFS_EP_CFG: ep_cfg_reg <= hwdata[7:0];
        PFM_OFS_TMR_IRQ: tmr_irq_reg <= hwdata[7:0];
        default: cpu_ctrl_reg <= cpu_ctrl_reg;
      endcase
      if (port_ok && (addr_reg[1:0] == 2'b00)) begin
        if ((addr_reg & PFM_OFS_GROUP_MASK) == PFM_OFS_PORT_DATA) begin
          port_data_reg[port_idx] <= hwdata[7:0];
        end
        if ((addr_reg & PFM_OFS_GROUP_MASK) == PFM_OFS_PORT_DIR) begin
          port_dir_reg[port_idx] <= hwdata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Function selection
  // ----------------------------------------------------------------
  logic wave_mode, slave_mode, fifo_mode, cs_sel, cs_active;
  logic out_en_active, data_drive, wake_asserted;
  logic [7:0] pa_out_n, pa_oe_n, pb_out_n, pb_oe_n, pc_out_n, pc_oe_n;
  logic [7:0] pd_out_n, pd_oe_n, pe_out_n, pe_oe_n, pe_alt;
  logic [1:0] irq_n, tmr_src, tmr_pend_reg, tmr_pulse_reg;
  logic t2_pulse_reg;

  assign wave_mode = ifc_cfg_reg[1:0] == PFM_MODE_WAVE;
  assign slave_mode = ifc_cfg_reg[1:0] == PFM_MODE_SLAVE;
  assign fifo_mode = wave_mode || slave_mode;
  assign cs_sel = slave_mode && !pa_sel_reg[7];
  assign cs_active = !cs_sel || !pa[7];
  assign out_en_active = slave_mode && cs_active &&
                         (pa[2] == fifo_pol_reg[PFM_BIT_SLV_OE_POL]);
  assign data_drive = wave_mode ? fifo_data_drive : out_en_active;
  assign wake_asserted = pa[3] == wakeup_reg[PFM_BIT_WAKE_POL];
  assign pe_alt = {waveform_address_out[8], 2'b00, uart1_rx_out,
                   uart0_rx_out, t2_pulse_reg, tmr_pulse_reg};

  always_comb begin
    pa_out_n = port_data_reg[0];
    pa_oe_n = port_dir_reg[0];
    pa_oe_n[1:0] = pa_oe_n[1:0] & ~pa_sel_reg[1:0];
    if (slave_mode) begin
      pa_oe_n[2] = 1'b0;
      pa_oe_n[5:4] = 2'b00;
      pa_oe_n[6] = 1'b0;
    end
    if (fifo_mode && pa_sel_reg[7]) begin
      pa_out_n[7] = fifo_status_flag_d;
      pa_oe_n[7] = 1'b1;
    end else if (cs_sel) begin
      pa_oe_n[7] = 1'b0;
    end
    pb_out_n = fifo_mode ? fifo_data_out[7:0] : port_data_reg[1];
    pb_oe_n = fifo_mode ? {8{data_drive}} : port_dir_reg[1];
    pc_out_n = (pc_sel_reg & waveform_address_out[7:0]) |
               (~pc_sel_reg & port_data_reg[2]);
    pc_oe_n = pc_sel_reg | port_dir_reg[2];
    if (fifo_mode && ep_cfg_reg[PFM_BIT_WORDWIDE]) begin
      pd_out_n = fifo_data_out[15:8];
      pd_oe_n = {8{data_drive}};
    end else begin
      pd_out_n = port_data_reg[3];
      pd_oe_n = port_dir_reg[3];
    end
    pe_out_n = (pe_sel_reg & pe_alt) | (~pe_sel_reg & port_data_reg[4]);
    pe_oe_n = (pe_sel_reg & 8'h9f) | (~pe_sel_reg & port_dir_reg[4]);
    for (int i = 0; i < 2; i++) begin
      irq_n[i] = pa_sel_reg[i] && (tmr_irq_reg[i] ?
                 (pa_prev_reg[i] && !pa[i]) : !pa[i]);
    end
  end

  // ----------------------------------------------------------------
  // Registered pins and internal signals
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {port_a_out, port_a_oe, port_b_out, port_b_oe} <= 32'h0000_0000;
      {port_c_out, port_c_oe, port_d_out, port_d_oe} <= 32'h0000_0000;
      {port_e_out, port_e_oe} <= 16'h0000;
      processor_clock_output <= 1'b0;
      processor_clock_output_oe <= 1'b0;
    end else begin
      {port_a_out, port_a_oe} <= {pa_out_n, pa_oe_n};
      {port_b_out, port_b_oe} <= {pb_out_n, pb_oe_n};
      {port_c_out, port_c_oe} <= {pc_out_n, pc_oe_n};
      {port_d_out, port_d_oe} <= {pd_out_n, pd_oe_n};
      {port_e_out, port_e_oe} <= {pe_out_n, pe_oe_n};
      processor_clock_output <= clk_fast_w;
      processor_clock_output_oe <=
        !cpu_ctrl_reg[PFM_BIT_CLK_TRISTATE] && !soft_rst;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pa_prev_reg <= 8'h00;
      {ext_irq_zero, ext_irq_one, slave_output_enable} <= 3'b000;
      {packet_commit, slave_chip_select, int6_in} <= 3'b000;
      {timer2_reload_in, oscillator_restart, wakeup_irq} <= 3'b000;
      suspend_inhibit <= 1'b0;
      fifo_select <= 2'b00;
      fifo_data_in <= 16'h0000;
      code_fetch_external <= 1'b0;
      chip_reset_active <= 1'b1;
    end else begin
      pa_prev_reg <= pa;
      {ext_irq_one, ext_irq_zero} <= irq_n & {2{!soft_rst}};
      slave_output_enable <= out_en_active;
      packet_commit <= slave_mode && cs_active &&
        (pa[6] == fifo_pol_reg[PFM_BIT_COMMIT_POL]);
      slave_chip_select <= slave_mode && cs_active;
      fifo_select <= slave_mode ? pa[5:4] : 2'b00;
      fifo_data_in <= {pd, pb};
      int6_in <= pe_sel_reg[5] && pe[5];
      timer2_reload_in <= pe_sel_reg[6] && pe[6];
      oscillator_restart <= wakeup_reg[PFM_BIT_WAKE_EN] && suspended &&
                            (pa[3] != pa_prev_reg[3]);
      wakeup_irq <= wakeup_reg[PFM_BIT_WAKE_EN] && suspended &&
                    (pa[3] != pa_prev_reg[3]);
      suspend_inhibit <= wakeup_reg[PFM_BIT_WAKE_EN] && wake_asserted;
      code_fetch_external <= (fetch_address > PFM_CODE_INT_LAST) ||
                             ext_sel_s;
      chip_reset_active <= soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // Timer overflow outputs
  // ----------------------------------------------------------------
  assign tmr_src[0] = tmr_irq_reg[PFM_BIT_T0_MODE3] ?
                      timer0_low_overflow : timer0_overflow;
  assign tmr_src[1] = tmr_irq_reg[PFM_BIT_T1_MODE3] ?
                      timer1_low_overflow : timer1_overflow;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_pend_reg <= 2'b00;
      tmr_pulse_reg <= 2'b00;
      t2_pulse_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rise_tick) begin
          tmr_pulse_reg[i] <= tmr_pend_reg[i];
          tmr_pend_reg[i] <= tmr_src[i];
        end else begin
          tmr_pend_reg[i] <= tmr_pend_reg[i] || tmr_src[i];
        end
      end
      t2_pulse_reg <= timer2_overflow;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_clk_tristate;
    @(posedge clk) disable iff (rst)
    cpu_ctrl_reg[PFM_BIT_CLK_TRISTATE] |=> !processor_clock_output_oe;
  endproperty
  a_clk_tristate: assert property (p_clk_tristate)
    else $error("clock output driven while tristate set");

  property p_port_b_idle;
    @(posedge clk) disable iff (rst)
    (fifo_mode && !data_drive) |=> (port_b_oe == 8'h00);
  endproperty
  a_port_b_idle: assert property (p_port_b_idle)
    else $error("port b driven in fifo mode without enable");

  property p_port_d_plain;
    @(posedge clk) disable iff (rst || soft_rst)
    (!fifo_mode || !ep_cfg_reg[PFM_BIT_WORDWIDE]) |=>
      (port_d_out == $past(port_data_reg[3]));
  endproperty
  a_port_d_plain: assert property (p_port_d_plain)
    else $error("port d left port function");

  property p_port_c_sel;
    @(posedge clk) disable iff (rst)
    pc_sel_reg[0] |=> (port_c_oe[0] && port_c_out[0] ==
                       $past(waveform_address_out[0]));
  endproperty
  a_port_c_sel: assert property (p_port_c_sel)
    else $error("port c bit 0 not carrying address");

  property p_irq_edge;
    @(posedge clk) disable iff (rst || soft_rst)
    (pa_sel_reg[0] && tmr_irq_reg[0] && pa_prev_reg[0] && !pa[0]) |=>
      ext_irq_zero ##1 !ext_irq_zero;
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("edge interrupt not a single pulse");

  property p_irq_level;
    @(posedge clk) disable iff (rst || soft_rst)
    (pa_sel_reg[1] && !tmr_irq_reg[1] && !pa[1]) |=> ext_irq_one;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("level interrupt missing");

  property p_suspend_inhibit;
    @(posedge clk) disable iff (rst)
    (wakeup_reg[PFM_BIT_WAKE_EN] && wake_asserted) |=> suspend_inhibit;
  endproperty
  a_suspend_inhibit: assert property (p_suspend_inhibit)
    else $error("suspend not inhibited");

  property p_t2_pulse;
    @(posedge clk) disable iff (rst)
    (pe_sel_reg[2] && timer2_overflow && !$past(timer2_overflow)) |=>
      ##1 (port_e_out[2] && port_e_oe[2]);
  endproperty
  a_t2_pulse: assert property (p_t2_pulse)
    else $error("timer 2 overflow output missing");

  property p_t0_align;
    @(posedge clk) disable iff (rst)
    $rose(tmr_pulse_reg[0]) |-> $past(rise_tick);
  endproperty
  a_t0_align: assert property (p_t0_align)
    else $error("timer 0 pulse not aligned to output clock");

  property p_reset_inputs;
    @(posedge clk) disable iff (rst)
    $past(soft_rst) && soft_rst |=> (port_a_oe == 8'h00 &&
      port_b_oe == 8'h00 && port_e_oe == 8'h00);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pin driven after reset");
endmodule : pfm_port_mux

/* File: testbench/pfm_far_end.sv */
// Far-end FIFO master driving port A and B pins.
// Assumes device enables decide who owns each pin.
`timescale 1ns/10ps
module pfm_far_end (
  input wire logic [7:0] a_req,
  input wire logic [7:0] b_req,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] a_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_out,
  output logic [7:0] a_pin,
  output logic [7:0] b_pin
);
  // Select, commit and enables from the master
  assign a_pin = (a_oe & a_out) | (~a_oe & a_req);
  assign b_pin = (b_oe & b_out) | (~b_oe & b_req);
endmodule : pfm_far_end

/* File: testbench/port_pin_function_mux_bench.sv */
// Self-checking bench for the port pin function multiplexer.
// Assumes the register map of pfm_pkg and a single AHB-Lite slave.
`timescale 1ns/10ps
module port_pin_function_mux_bench;
  import pfm_pkg::*;
  logic clk, rst, hsel, hwrite, hresp, hreadyout, chip_reset_n;
  logic external_code_select, code_fetch_external, chip_reset_active;
  logic processor_clock_output, processor_clock_output_oe, fifo_data_drive;
  logic fifo_status_flag_d, uart0_rx_out, uart1_rx_out, timer0_overflow;
  logic timer0_low_overflow, timer1_overflow, timer1_low_overflow;
  logic timer2_overflow, suspended, ext_irq_zero, ext_irq_one;
  logic slave_output_enable, packet_commit, slave_chip_select, int6_in;
  logic timer2_reload_in, oscillator_restart, wakeup_irq, suspend_inhibit;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] fetch_address, fifo_data_out, fifo_data_in;
  logic [8:0] waveform_address_out;
  logic [7:0] port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out;
  logic [7:0] port_b_oe, port_c_in, port_c_out, port_c_oe, port_d_in;
  logic [7:0] port_d_out, port_d_oe, port_e_in, port_e_out, port_e_oe;
  logic [7:0] a_req, b_req;
  logic [2:0] hsize;
  logic [1:0] htrans, fifo_select;
  int mismatches, samples_checked, cycles, n, m, k;
  pfm_port_mux dut (.hready(hreadyout), .*);
  pfm_far_end far (.a_req(a_req), .b_req(b_req), .a_oe(port_a_oe),
    .a_out(port_a_out), .b_oe(port_b_oe), .b_out(port_b_out),
    .a_pin(port_a_in), .b_pin(port_b_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle
  task automatic end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    rst <= 1'b1;
    {hwrite, htrans, haddr, hwdata, external_code_select, fetch_address} <= '0;
    {fifo_data_drive, fifo_status_flag_d, suspended, timer0_overflow} <= '0;
    {timer0_low_overflow, timer1_overflow, timer1_low_overflow} <= '0;
    {timer2_overflow, waveform_address_out, port_c_in, port_d_in} <= '0;
    {uart0_rx_out, uart1_rx_out, chip_reset_n, hsel} <= '1;
    port_e_in <= 8'h00;
    fifo_data_out <= 16'h96a5;
    hsize <= 3'b010;
    a_req <= 8'hff;
    b_req <= 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle;
    rd(PFM_OFS_CPU_CTRL, 32'h0);
    rd(PFM_OFS_IFC_CFG, 32'h0);
    chk(port_a_oe | port_b_oe | port_c_oe | port_d_oe | port_e_oe, 0);
    chk(processor_clock_output_oe, 1);
    wr(PFM_OFS_CPU_CTRL, 32'h2);
    settle;
    chk(processor_clock_output_oe, 0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      external_code_select <= (i == 2);
      fetch_address <= (i == 1) ? 16'h4000 : 16'h3fff;
      settle;
      chk(code_fetch_external, i > 0);
    end
    wr(PFM_OFS_PA_SEL, 32'h3);
    @(posedge clk);
    a_req <= 8'hfe;
    settle;
    chk({port_a_oe[1:0], ext_irq_one, ext_irq_zero}, 4'h1);
    wr(PFM_OFS_IFC_CFG, 32'h3);
    wr(PFM_OFS_FIFO_POL, 32'h30);
    @(posedge clk);
    a_req <= 8'h64;
    b_req <= 8'h5a;
    settle;
    chk({slave_output_enable, packet_commit, fifo_select}, 4'he);
    chk(slave_chip_select, 1);
    chk({port_b_oe, port_b_out, port_d_oe}, 24'hffa500);
    wr(PFM_OFS_EP_CFG, 32'h1);
    settle;
    chk(port_d_out, 8'h96);
    wr(PFM_OFS_FIFO_POL, 32'h20);
    settle;
    chk({slave_output_enable, port_b_oe}, 0);
    wr(PFM_OFS_WAKEUP, 32'h12);
    @(posedge clk);
    suspended <= 1'b1;
    a_req <= 8'h6c;
    n = 0;
    repeat (6) begin
      @(negedge clk);
      n += oscillator_restart + wakeup_irq;
    end
    chk(n, 2);
    rd(PFM_OFS_STATUS, 32'hf);
    chk(fifo_data_in, 16'h005a);
    wr(PFM_OFS_PC_SEL, 32'hff);
    @(posedge clk);
    waveform_address_out <= 9'h15a;
    settle;
    chk({port_c_oe, port_c_out}, 16'hff5a);
    rd(PFM_OFS_PC_SEL, 32'hff);
    rd(8'hfc, 32'h0);
    wr(PFM_OFS_IFC_CFG, 32'h2);
    @(posedge clk);
    fifo_data_drive <= 1'b1;
    settle;
    chk(port_b_oe, 8'hff);
    wr(PFM_OFS_PE_SEL, 32'h9f);
    @(posedge clk);
    {timer0_overflow, timer1_overflow, timer2_overflow} <= 3'b111;
    @(posedge clk);
    {timer0_overflow, timer1_overflow, timer2_overflow} <= 3'b000;
    n = 0;
    m = 0;
    k = 0;
    repeat (40) begin
      @(negedge clk);
      n += port_e_out[2];
      m += port_e_out[0];
      k += port_e_out[1];
    end
    chk(n, 1);
    chk(m, 2 * (PFM_HALF_SLOW + 1));
    chk(k, 2 * (PFM_HALF_SLOW + 1));
    chk(port_e_out & 8'h98, 8'h98);
    @(posedge clk);
    chip_reset_n <= 1'b0;
    settle;
    chk(chip_reset_active, 1);
    @(posedge clk);
    chip_reset_n <= 1'b1;
    settle;
    rd(PFM_OFS_PC_SEL, 32'h0);
    chk(port_c_oe | port_e_oe, 0);
    end_of_test();
  end
endmodule : port_pin_function_mux_bench
